// *** shared/csss_pkg.sv ***
// Operation
// - Full-performance low supervisor masks about 2 us
// - Normal-mode low supervisor masks about 150 us
// - Core low after mask expiry trips reset
// - Control write arms delay flags; deep waits
// - Low side off or full: fast wake
// - Low full-perf cleared: wake takes 150 us
// - High side may drop normal to off
// - Keep bit clear: off in deep, rearm
// - Low side normal mode selects slow wake
package csss_pkg;

   localparam int CLK_PERIOD_NS      = 10;
   localparam int MASK_FP_NS         = 2000;
   localparam int MASK_SLOW_NS       = 150000;
   localparam int MASK_FP_CYC        = (MASK_FP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MASK_SLOW_CYC_DEF  = (MASK_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W              = 16;

   // Register byte offsets
   localparam logic [7:0] OFS_LOW_CTRL   = 8'h00;
   localparam logic [7:0] OFS_HIGH_CTRL  = 8'h04;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h0c;
   localparam logic [7:0] OFS_STATE      = 8'h10;

   // Control register fields, same layout on both sides
   localparam int CTL_SUP_EN   = 0;
   localparam int CTL_SUP_FP   = 1;
   localparam int CTL_SUP_KEEP = 2;
   localparam int CTL_MON_EN   = 3;
   localparam int CTL_MON_FP   = 4;
   localparam int CTL_AUTO     = 5;
   localparam int CTL_W        = 6;
   localparam logic [CTL_W-1:0] CTL_RST = 6'h01;

   // Interrupt status fields
   localparam int IRQ_LOW_DONE  = 0;
   localparam int IRQ_HIGH_DONE = 1;
   localparam int IRQ_LOW_TRIP  = 2;
   localparam int IRQ_HIGH_TRIP = 3;
   localparam int IRQ_WAKE_DONE = 4;
   localparam int IRQ_W         = 5;
   localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;

   // State register fields
   localparam int STA_DLY_LSB  = 0;
   localparam int STA_UNIT_LSB = 2;
   localparam int STA_SLOW     = 10;
   localparam int STA_PWR_LSB  = 11;

   typedef enum logic [1:0] {
      SUP_OFF    = 2'b00,
      SUP_NORMAL = 2'b01,
      SUP_FULL   = 2'b10
   } csss_sup_st_t;

   typedef enum logic [1:0] {
      PWR_ACTIVE = 2'b00,
      PWR_DEEP   = 2'b01,
      PWR_WAKING = 2'b10
   } csss_pwr_t;

endpackage : csss_pkg

// *** rtl/csss_mode_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
module csss_mode_decode
   import csss_pkg::*;
(
   input  wire logic         enable_i,
   input  wire logic         full_perf_i,
   input  wire logic         keep_i,
   input  wire logic         auto_i,
   input  wire logic         deep_i,
   output var csss_sup_st_t  state_o
);

   always_comb
   begin
      if (!enable_i)
         state_o = SUP_OFF;
      else if (!deep_i)
         state_o = full_perf_i ? SUP_FULL : SUP_NORMAL;
      else if (auto_i)
         state_o = (keep_i && full_perf_i) ? SUP_NORMAL : SUP_OFF;
      else if (keep_i)
         state_o = full_perf_i ? SUP_FULL : SUP_NORMAL;
      else
         state_o = SUP_OFF;
   end

endmodule : csss_mode_decode
`default_nettype wire

// *** rtl/csss_top.sv ***
// Local design decisions: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none
module csss_top
   import csss_pkg::*;
#(
   parameter int MASK_SLOW_CYC = MASK_SLOW_CYC_DEF
)
(
   input  wire logic          REF_CLK_I,
   input  wire logic          RST_N_I,
   input  wire logic          PSEL_I,
   input  wire logic          PENABLE_I,
   input  wire logic          PWRITE_I,
   input  wire logic [7:0]    PADDR_I,
   input  wire logic [31:0]   PWDATA_I,
   output logic      [31:0]   PRDATA_O,
   output logic               PREADY_O,
   output logic               PSLVERR_O,
   input  wire logic          DEEP_SLEEP_REQ_I,
   input  wire logic          WAKE_REQ_I,
   input  wire logic          LOW_CORE_OK_I,
   input  wire logic          HIGH_SUPPLY_OK_I,
   output logic               DEEP_SLEEP_O,
   output logic               WAKE_DONE_O,
   output logic               SLOW_WAKE_O,
   output logic      [1:0]    DELAY_FLAGS_O,
   output logic      [7:0]    SUP_STATE_O,
   output logic               RESET_REQ_O,
   output logic               IRQ_O
);

   logic                rst_meta_q;
   logic                rst_sync_q;
   logic                rst_n;

   logic [CTL_W-1:0]    ctl_q       [2];
   logic [IRQ_W-1:0]    irq_st_q;
   logic [IRQ_W-1:0]    irq_mask_q;
   logic [IRQ_W-1:0]    irq_set;
   csss_pwr_t           pwr_q;
   csss_sup_st_t        unit_st_d   [4];
   csss_sup_st_t        unit_st_q   [4];
   logic [CNT_W-1:0]    mask_cnt_q  [2];
   logic [1:0]          dly_q;
   logic [1:0]          mask_start;
   logic [1:0]          mask_done;
   logic [1:0]          trip;
   logic [1:0]          supply_ok;
   logic [CNT_W-1:0]    wake_cnt_q;
   logic                wake_begin;
   logic                deep_enter;
   logic                slow_wake;

   logic                apb_setup;
   logic                apb_acc;
   logic                wr_acc;
   logic [1:0]          ctl_wr;
   logic [31:0]         rdata_d;
   logic                err_d;
   logic [31:0]         state_word;

   // Reset release through two stages
   always_ff @(posedge REF_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // APB slave: ready is raised for the first access cycle, no extra wait
   assign apb_setup = PSEL_I && !PENABLE_I;
   assign apb_acc   = PSEL_I && PENABLE_I && PREADY_O;
   assign wr_acc    = apb_acc && PWRITE_I;
   assign ctl_wr[0] = wr_acc && (PADDR_I == OFS_LOW_CTRL);
   assign ctl_wr[1] = wr_acc && (PADDR_I == OFS_HIGH_CTRL);

   always_comb
   begin
      state_word = 32'h0;
      state_word[STA_DLY_LSB +: 2] = dly_q;
      state_word[STA_UNIT_LSB +: 8] = SUP_STATE_O;
      state_word[STA_SLOW] = slow_wake;
      state_word[STA_PWR_LSB +: 2] = pwr_q;
   end

   always_comb
   begin
      rdata_d = 32'h0;
      err_d   = 1'b0;
      case (PADDR_I)
         OFS_LOW_CTRL:   rdata_d[CTL_W-1:0] = ctl_q[0];
         OFS_HIGH_CTRL:  rdata_d[CTL_W-1:0] = ctl_q[1];
         OFS_IRQ_STATUS: rdata_d[IRQ_W-1:0] = irq_st_q;
         OFS_IRQ_MASK:   rdata_d[IRQ_W-1:0] = irq_mask_q;
         OFS_STATE:      rdata_d = state_word;
         default:        err_d = 1'b1;
      endcase
   end

   always_ff @(posedge REF_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         PREADY_O  <= 1'b0;
         PRDATA_O  <= 32'h0;
         PSLVERR_O <= 1'b0;
      end
      else
      begin
         PREADY_O  <= apb_setup;
         PRDATA_O  <= (apb_setup && !PWRITE_I) ? rdata_d : 32'h0;
         PSLVERR_O <= apb_setup && err_d;
      end
   end

   // Control registers; the state register is read-only
   always_ff @(posedge REF_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctl_q[0]   <= CTL_RST;
         ctl_q[1]   <= CTL_RST;
         irq_mask_q <= IRQ_RST;
      end
      else
      begin
         if (ctl_wr[0])
            ctl_q[0] <= PWDATA_I[CTL_W-1:0];
         if (ctl_wr[1])
            ctl_q[1] <= PWDATA_I[CTL_W-1:0];
         if (wr_acc && (PADDR_I == OFS_IRQ_MASK))
            irq_mask_q <= PWDATA_I[IRQ_W-1:0];
      end
   end

   // Sticky status; a new event wins over a same-cycle clear
   assign irq_set[IRQ_LOW_DONE]  = mask_done[0];
   assign irq_set[IRQ_HIGH_DONE] = mask_done[1];
   assign irq_set[IRQ_LOW_TRIP]  = trip[0];
   assign irq_set[IRQ_HIGH_TRIP] = trip[1];
   assign irq_set[IRQ_WAKE_DONE] = (pwr_q == PWR_WAKING) && (wake_cnt_q == 16'h0001);

   always_ff @(posedge REF_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_st_q <= IRQ_RST;
         IRQ_O    <= 1'b0;
      end
      else
      begin
         if (wr_acc && (PADDR_I == OFS_IRQ_STATUS))
            irq_st_q <= (irq_st_q & ~PWDATA_I[IRQ_W-1:0]) | irq_set;
         else
            irq_st_q <= irq_st_q | irq_set;
         IRQ_O <= |(irq_st_q & irq_mask_q);
      end
   end

   // Any enabled low unit in normal mode forces slow wake-up
   assign slow_wake = (ctl_q[0][CTL_SUP_EN] && !ctl_q[0][CTL_SUP_FP])
                   || (ctl_q[0][CTL_MON_EN] && !ctl_q[0][CTL_MON_FP]);

   // Entry refused while either settling delay is still running
   assign deep_enter = (pwr_q == PWR_ACTIVE) && DEEP_SLEEP_REQ_I && (dly_q == 2'b00);
   assign wake_begin = (pwr_q == PWR_DEEP) && WAKE_REQ_I;

   always_ff @(posedge REF_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pwr_q       <= PWR_ACTIVE;
         wake_cnt_q  <= '0;
         WAKE_DONE_O <= 1'b0;
      end
      else
      begin
         WAKE_DONE_O <= 1'b0;
         case (pwr_q)
            PWR_ACTIVE:
            begin
               if (deep_enter)
                  pwr_q <= PWR_DEEP;
            end
            PWR_DEEP:
            begin
               if (wake_begin)
               begin
                  pwr_q      <= PWR_WAKING;
                  wake_cnt_q <= slow_wake ? CNT_W'(MASK_SLOW_CYC) : CNT_W'(MASK_FP_CYC);
               end
            end
            PWR_WAKING:
            begin
               if (wake_cnt_q <= 16'h0001)
               begin
                  pwr_q       <= PWR_ACTIVE;
                  wake_cnt_q  <= '0;
                  WAKE_DONE_O <= 1'b1;
               end
               else
                  wake_cnt_q <= wake_cnt_q - 16'h0001;
            end
            default:
               pwr_q <= PWR_ACTIVE;
         endcase
      end
   end

   // Per unit: 0 low sup, 1 low mon, 2 high sup, 3 high mon
   for (genvar u = 0; u < 4; u++)
   begin : g_unit
      localparam int SIDE = u / 2;
      localparam bit MON  = (u % 2) == 1;

      csss_mode_decode u_dec (
         .enable_i    (MON ? ctl_q[SIDE][CTL_MON_EN] : ctl_q[SIDE][CTL_SUP_EN]),
         .full_perf_i (MON ? ctl_q[SIDE][CTL_MON_FP] : ctl_q[SIDE][CTL_SUP_FP]),
         .keep_i      (MON ? 1'b1 : ctl_q[SIDE][CTL_SUP_KEEP]),
         .auto_i      (ctl_q[SIDE][CTL_AUTO]),
         .deep_i      (pwr_q == PWR_DEEP),
         .state_o     (unit_st_d[u])
      );

      always_ff @(posedge REF_CLK_I or negedge rst_n)
      begin
         if (!rst_n)
            unit_st_q[u] <= SUP_OFF;
         else
            unit_st_q[u] <= unit_st_d[u];
      end

      assign SUP_STATE_O[2*u +: 2] = unit_st_q[u];
   end

   assign supply_ok[0] = LOW_CORE_OK_I;
   assign supply_ok[1] = HIGH_SUPPLY_OK_I;

   // Per side settling mask; its length follows the supervisor's mode
   for (genvar s = 0; s < 2; s++)
   begin : g_side
      logic [CNT_W-1:0] cnt_d;
      logic             fp_sel;

      // A write arms the mask of the mode it sets, so clearing full
      // performance before a core raise gets the long mask at once
      assign fp_sel = ctl_wr[s] ? PWDATA_I[CTL_SUP_FP] : ctl_q[s][CTL_SUP_FP];
      assign mask_start[s] = ctl_wr[s] || wake_begin;
      assign mask_done[s]  = mask_cnt_q[s] == 16'h0001;
      assign trip[s]       = (unit_st_q[2*s] != SUP_OFF) && !dly_q[s] && !supply_ok[s];

      always_comb
      begin
         if (mask_start[s])
            cnt_d = fp_sel ? CNT_W'(MASK_FP_CYC) : CNT_W'(MASK_SLOW_CYC);
         else if (mask_cnt_q[s] != '0)
            cnt_d = mask_cnt_q[s] - 16'h0001;
         else
            cnt_d = '0;
      end

      always_ff @(posedge REF_CLK_I or negedge rst_n)
      begin
         if (!rst_n)
         begin
            mask_cnt_q[s] <= '0;
            dly_q[s]      <= 1'b0;
         end
         else
         begin
            mask_cnt_q[s] <= cnt_d;
            dly_q[s]      <= cnt_d != '0;
         end
      end
   end

   always_ff @(posedge REF_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         RESET_REQ_O   <= 1'b0;
         DEEP_SLEEP_O  <= 1'b0;
         SLOW_WAKE_O   <= 1'b0;
         DELAY_FLAGS_O <= 2'b00;
      end
      else
      begin
         RESET_REQ_O   <= |trip;
         DEEP_SLEEP_O  <= deep_enter || ((pwr_q == PWR_DEEP) && !wake_begin);
         SLOW_WAKE_O   <= slow_wake;
         DELAY_FLAGS_O <= (mask_start | {mask_cnt_q[1] > 16'h0001, mask_cnt_q[0] > 16'h0001});
      end
   end

   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!rst_n);

   AST_LOW_FP_MASK: assert property (
      mask_start[0] && (ctl_wr[0] ? PWDATA_I[CTL_SUP_FP] : ctl_q[0][CTL_SUP_FP])
      |=> mask_cnt_q[0] == CNT_W'(MASK_FP_CYC))
      else $error("Full-performance mask length wrong");

   AST_LOW_NORM_MASK: assert property (
      mask_start[0] && !(ctl_wr[0] ? PWDATA_I[CTL_SUP_FP] : ctl_q[0][CTL_SUP_FP])
      |=> mask_cnt_q[0] == CNT_W'(MASK_SLOW_CYC))
      else $error("Normal-mode mask length wrong");

   AST_TRIP_RESET: assert property (
      (unit_st_q[0] != SUP_OFF) && !dly_q[0] && !LOW_CORE_OK_I |=> RESET_REQ_O && irq_st_q[IRQ_LOW_TRIP])
      else $error("Low side trip did not request reset");

   AST_MASKED_NO_TRIP: assert property (
      dly_q == 2'b11 |=> !RESET_REQ_O)
      else $error("Reset requested inside settling mask");

   AST_DEEP_GATED: assert property (
      (pwr_q == PWR_ACTIVE) && (dly_q != 2'b00) |=> pwr_q == PWR_ACTIVE)
      else $error("Deep entry while delay flag set");

   AST_WAKE_SLOW: assert property (
      wake_begin && slow_wake |=> (pwr_q == PWR_WAKING) && wake_cnt_q == CNT_W'(MASK_SLOW_CYC))
      else $error("Slow wake time not loaded");

   AST_WAKE_FAST: assert property (
      wake_begin && !slow_wake |=> wake_cnt_q == CNT_W'(MASK_FP_CYC) ##200 WAKE_DONE_O)
      else $error("Fast wake did not finish in time");

   AST_AUTO_FP_NORMAL: assert property (
      (pwr_q == PWR_DEEP) && ctl_q[0][CTL_AUTO] && ctl_q[0][CTL_MON_EN] && ctl_q[0][CTL_MON_FP]
      |=> unit_st_q[1] == SUP_NORMAL)
      else $error("Auto mode full monitor not normal in deep");

   AST_KEEP_OFF: assert property (
      (pwr_q == PWR_DEEP) && !ctl_q[1][CTL_SUP_KEEP] && !ctl_wr[1] |=> unit_st_q[2] == SUP_OFF)
      else $error("High supervisor not off in deep");

   AST_WAKE_REARM: assert property (
      wake_begin |=> dly_q == 2'b11 && DEEP_SLEEP_O == 1'b0)
      else $error("Wake did not rearm settling masks");

   AST_SLOW_SEL: assert property (
      ctl_q[0][CTL_SUP_EN] && !ctl_q[0][CTL_SUP_FP] && !ctl_wr[0] |=> SLOW_WAKE_O)
      else $error("Normal low supervisor did not select slow wake");

endmodule : csss_top
`default_nettype wire

// *** testbench/core_supply_supervisor_modes_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module core_supply_supervisor_modes_bench
   import csss_pkg::*;
;
   localparam int SLOW = 40;
   localparam int LIM  = 20000;
   localparam logic [32:0] MK = 33'h1_ffff_ffff;
   localparam logic [32:0] MF = 33'h1_ffff_fffc;
   typedef struct {
      string       name;
      logic [32:0] val;
      logic [32:0] msk;
   } csss_note_t;

   logic        clk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic        deep_req;
   logic        wake_req;
   logic        low_ok;
   logic        high_ok;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        deep_o;
   logic        wake_done;
   logic        slow_wake;
   logic [1:0]  dly;
   logic [7:0]  sup_st;
   logic        rst_req;
   logic        irq;
   logic [5:0]  mon;
   logic        meas_stb;
   logic [32:0] meas_v;
   logic [32:0] got;
   logic [31:0] r;
   csss_note_t  note_q[$];
   csss_note_t  nt;
   int          fail_count;
   int          checked;
   int          seed;
   int          n;
   logic [31:0] cfg [2]  = '{32'h27, 32'h0d};
   logic [31:0] dexp [2] = '{32'h804, 32'hc14};
   logic [31:0] aexp [2] = '{32'h48, 32'h454};
   int          wn [2]   = '{MASK_FP_CYC, SLOW};

   assign mon = {irq, rst_req, deep_o, wake_done, dly};

   csss_top #(.MASK_SLOW_CYC(SLOW)) DUT (
      .REF_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .DEEP_SLEEP_REQ_I(deep_req),
      .WAKE_REQ_I(wake_req), .LOW_CORE_OK_I(low_ok), .HIGH_SUPPLY_OK_I(high_ok),
      .DEEP_SLEEP_O(deep_o), .WAKE_DONE_O(wake_done), .SLOW_WAKE_O(slow_wake),
      .DELAY_FLAGS_O(dly), .SUP_STATE_O(sup_st), .RESET_REQ_O(rst_req),
      .IRQ_O(irq));

   always #5 clk = ~clk;

   // Oldest note pairs with each completed read or measurement
   always @(posedge clk)
   begin
      if ((psel && penable && pready === 1'b1 && !pwrite) || meas_stb)
      begin
         nt = note_q.pop_front();
         got = meas_stb ? meas_v : {pslverr, prdata};
         checked++;
         if ((got & nt.msk) !== (nt.val & nt.msk))
         begin
            fail_count++;
            $display("Error %s expected %h seen %h", nt.name, nt.val & nt.msk, got & nt.msk);
         end
      end
   end

   task automatic end_of_test();
      if (fail_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      @(posedge clk);
      while (pready !== 1'b1 && k < 50)
      begin
         k++;
         @(posedge clk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 50)
      begin
         fail_count++;
         end_of_test();
      end
   endtask : apb

   task automatic rd(input string nm, input logic [7:0] a, input logic [32:0] v,
                     input logic [32:0] m);
      note_q.push_back('{nm, v, m});
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic meas(input string nm, input logic [32:0] v, input logic [32:0] g);
      note_q.push_back('{nm, v, MK});
      @(posedge clk);
      meas_v <= g;
      meas_stb <= 1'b1;
      @(posedge clk);
      meas_stb <= 1'b0;
   endtask : meas

   // Counts sampled cycles while a monitored bit holds a level
   task automatic cnt(input int b, input logic lvl, output int c);
      c = 0;
      @(posedge clk);
      while (mon[b] === lvl && c < LIM)
      begin
         c++;
         @(posedge clk);
      end
      if (c == LIM)
      begin
         fail_count++;
         end_of_test();
      end
   endtask : cnt

   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      {psel, penable, pwrite, deep_req, wake_req, meas_stb} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      meas_v = '0;
      low_ok = 1'b1;
      high_ok = 1'b1;
      seed = 32'h2600;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd("low ctrl", OFS_LOW_CTRL, 33'(CTL_RST), MK);
      rd("high ctrl", OFS_HIGH_CTRL, 33'(CTL_RST), MK);
      rd("unmapped", 8'h14, 33'h1_0000_0000, MK);
      rd("reset state", OFS_STATE, 33'h444, MK);
      apb(1'b1, OFS_STATE, 32'hffff_ffff);
      rd("state ro", OFS_STATE, 33'h444, MK);
      repeat (4)
      begin
         r = $random(seed);
         apb(1'b1, OFS_IRQ_MASK, {27'h0, r[4:0]});
         rd("irq mask", OFS_IRQ_MASK, {28'h0, r[4:0]}, MK);
      end
      apb(1'b1, OFS_IRQ_MASK, 32'h0);
      apb(1'b1, OFS_LOW_CTRL, 32'h01);
      cnt(0, 1'b1, n);
      meas("normal mask", 33'(SLOW), 33'(n));
      rd("done status", OFS_IRQ_STATUS, 33'h1, 33'h1);
      apb(1'b1, OFS_LOW_CTRL, 32'h03);
      cnt(0, 1'b1, n);
      // The written mode decides the mask, so this one has the full-performance length
      meas("switch mask", 33'(MASK_FP_CYC), 33'(n));
      apb(1'b1, OFS_LOW_CTRL, 32'h03);
      cnt(0, 1'b1, n);
      meas("full mask", 33'(MASK_FP_CYC), 33'(n));
      rd("fast state", OFS_STATE, 33'h48, MK);
      apb(1'b1, OFS_HIGH_CTRL, 32'h01);
      deep_req <= 1'b1;
      repeat (10) @(posedge clk);
      meas("deep refused", 33'h0, 33'(deep_o));
      deep_req <= 1'b0;
      cnt(1, 1'b1, n);
      for (int i = 0; i < 2; i++)
      begin
         apb(1'b1, OFS_LOW_CTRL, cfg[i]);
         cnt(0, 1'b1, n);
         meas("mode mask", 33'(wn[i]), 33'(n));
         deep_req <= 1'b1;
         cnt(3, 1'b0, n);
         deep_req <= 1'b0;
         rd("deep state", OFS_STATE, 33'(dexp[i]), MK);
         meas("slow pin", 33'(i), 33'(slow_wake));
         meas("unit pins", 33'(dexp[i][9:2]), 33'(sup_st));
         wake_req <= 1'b1;
         cnt(3, 1'b1, n);
         wake_req <= 1'b0;
         cnt(2, 1'b0, n);
         meas("wake time", 33'(wn[i]), 33'(n + 1));
         rd("awake state", OFS_STATE, 33'(aexp[i]), MF);
      end
      apb(1'b1, OFS_IRQ_STATUS, 32'h1f);
      apb(1'b1, OFS_IRQ_MASK, 32'h04);
      low_ok <= 1'b0;
      cnt(4, 1'b0, n);
      low_ok <= 1'b1;
      meas("trip delay", 33'h1, 33'(n));
      repeat (2) @(posedge clk);
      meas("irq up", 33'h1, 33'(irq));
      apb(1'b1, OFS_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk);
      meas("irq masked", 33'h0, 33'(irq));
      apb(1'b1, OFS_IRQ_MASK, 32'h04);
      apb(1'b1, OFS_IRQ_STATUS, 32'h04);
      repeat (2) @(posedge clk);
      meas("irq cleared", 33'h0, 33'(irq));
      rd("trip status", OFS_IRQ_STATUS, 33'h0, 33'h4);
      // Normal mode written first, then a ramp shorter than the normal-mode mask
      apb(1'b1, OFS_LOW_CTRL, 32'h0d);
      low_ok <= 1'b0;
      repeat (SLOW / 2) @(posedge clk);
      low_ok <= 1'b1;
      rd("ramp covered", OFS_IRQ_STATUS, 33'h0, 33'h4);
      end_of_test();
   end
endmodule : core_supply_supervisor_modes_bench
`default_nettype wire
